// File: tst_defs.svh
// Offsets, field positions, status codes and reset values of the two-wire slave transmitter.
`ifndef TST_DEFS_SVH
`define TST_DEFS_SVH
`define TST_OFF_CTRL 8'h00
`define TST_OFF_STATUS 8'h04
`define TST_OFF_DATA 8'h08
`define TST_OFF_ADDR 8'h0C
`define TST_CTRL_FLAG 7
`define TST_CTRL_ACK 6
`define TST_CTRL_START 5
`define TST_CTRL_STOP 4
`define TST_CTRL_EN 2
`define TST_PRESC_MASK 8'hF8
`define TST_CODE_A8 8'hA8
`define TST_CODE_B0 8'hB0
`define TST_CODE_B8 8'hB8
`define TST_CODE_C0 8'hC0
`define TST_CODE_C8 8'hC8
`define TST_CODE_F8 8'hF8
`define TST_CODE_00 8'h00
`define TST_IDLE_BYTE 8'hFF
`define TST_RST_ACK 1'b0
`define TST_RST_EN 1'b0
`define TST_RST_OWN 7'h00
`define TST_RST_GCE 1'b0
`endif

// File: tst_master_model.sv
// Behavioural two-wire master receiver that drives the open-drain bus lines.
`timescale 1ns/1ps
`default_nettype none
module tst_master_model (
  // Clock.
  input wire logic clk_in,
  // Resolved bus levels.
  input wire logic scl_in,
  input wire logic sda_in,
  // Line pull-down enables.
  output logic scl_oe_out,
  output logic sda_oe_out
);
  initial begin
    scl_oe_out = 1'b0;
    sda_oe_out = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // A stretching slave may hold the clock for long; the bench timeout bounds this wait.
  task automatic rise();
    scl_oe_out <= 1'b0;
    @(posedge clk_in);
    while (scl_in !== 1'b1) @(posedge clk_in);
  endtask
  task automatic fall();
    scl_oe_out <= 1'b1;
    tick(1);
  endtask
  // Low for five cycles and high for three gives a 400 ns bit; data moves early in the low.
  task automatic clk_bit(input logic drv, input logic b, output logic got);
    fall();
    sda_oe_out <= drv & ~b;
    tick(4);
    rise();
    tick(2);
    got = sda_in;
  endtask
  task automatic start_cond();
    sda_oe_out <= 1'b0;
    tick(2);
    rise();
    tick(2);
    sda_oe_out <= 1'b1;
    tick(2);
    fall();
  endtask
  task automatic stop_cond();
    sda_oe_out <= 1'b1;
    tick(2);
    rise();
    tick(2);
    sda_oe_out <= 1'b0;
    tick(4);
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, b[i], g);
    end
    clk_bit(1'b0, 1'b1, ack);
    fall();
  endtask
  task automatic recv_byte(input logic ack, output logic [7:0] b);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b0, 1'b1, g);
      b[i] = g;
    end
    clk_bit(1'b1, ack, g);
    fall();
  endtask
endmodule
`default_nettype wire

// File: tst_pkg.sv
// Types shared by the two-wire slave transmitter and its bench.
`default_nettype none
package tst_pkg;
  typedef enum logic [7:0] {
    TST_IDLE = 8'b0000_0001,
    TST_ADDR = 8'b0000_0010,
    TST_ADDR_ACK = 8'b0000_0100,
    TST_WAIT = 8'b0000_1000,
    TST_TX = 8'b0001_0000,
    TST_TX_ACK = 8'b0010_0000,
    TST_IGNORE = 8'b0100_0000,
    TST_BERR = 8'b1000_0000
  } tst_fsm_type;
  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } tst_line_type;
  typedef struct packed {
    tst_fsm_type fsm;
    logic flag;
    logic ack_en;
    logic start_req;
    logic stop_req;
    logic enable;
    logic [6:0] own_addr;
    logic gce;
    logic [7:0] code;
    logic [7:0] shift;
    logic [7:0] data_last;
    logic [3:0] bitcnt;
    logic last;
    logic ackbit;
    logic arb_pend;
    logic start_pend;
    logic start_pulse;
    logic busy;
    logic scl_s1;
    logic scl_s2;
    logic scl_p;
    logic sda_s1;
    logic sda_s2;
    logic sda_p;
    logic scl_oe;
    logic sda_oe;
    logic [31:0] rdata;
  } tst_state_type;
endpackage
`default_nettype wire

// File: tst_slave_tx.sv
// Two-wire slave transmitter status logic with APB registers and a transmit byte buffer.
//
// Overview of operation
// - Own address with read bit acked: set event flag, status 0xA8.
// - Addressed for read after lost arbitration: acknowledge, status 0xB0.
// - Byte sent and master acked: set event flag, status 0xB8.
// - Byte sent and master not acked: set event flag, status 0xC0.
// - Last byte sent yet master acked: status 0xC8.
// - In A8, B0, B8 a clear with ack enable sends next byte expecting ACK.
// - In A8, B0, B8 a clear without ack enable sends final byte.
// - In C0, C8 a clear without ack enable: unaddressed, no address recognition.
// - In C0, C8 a clear with ack enable: unaddressed, own address recognised, general call not.
// - In C0, C8 a clear with start request issues START once bus is free.
// - Status reads 0xF8 while the event flag is clear.
// - START or STOP inside a byte or acknowledge is a bus error, status 0x00.
// - A bus error sets the event flag.
// - Recovery enters unaddressed mode and clears only the stop request.
// - Both lines are released when the bus error is detected; recovery sends no STOP.
// - Status codes read with the prescaler bits zero.
// - After the final byte the device drops out; the master reads all ones.
`timescale 1ns/1ps
`include "tst_defs.svh"
`default_nettype none

module tst_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_in,
  // Filling side.
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Draining side.
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } tst_fifo_state_type;
  tst_fifo_state_type s;
  tst_fifo_state_type n;
  logic push;
  logic pop;

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_size
    $error("Buffer depth must be a power of two of at least two.");
  end

  assign in_ready_out = (s.cnt != DEPTH[AW:0]);
  assign out_valid_out = (s.cnt != '0);
  assign out_data_out = s.mem[s.rp];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_ready_in & out_valid_out;

  always_comb begin
    n = s;
    if (push) begin
      n.mem[s.wp] = in_data_in;
      n.wp = s.wp + 1'b1;
    end
    if (pop) begin
      n.rp = s.rp + 1'b1;
    end
    n.cnt = s.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
endmodule

module tst_slave_tx #(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_in,
  // APB register port.
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Two-wire bus lines, open drain.
  input wire logic scl_in,
  input wire logic sda_in,
  output tst_pkg::tst_line_type lines_out,
  // Neighbouring master logic.
  input wire logic arb_lost_in,
  output logic master_start_out,
  output logic event_flag_out
);
  import tst_pkg::*;

  tst_state_type s;
  tst_state_type n;
  logic scl_rise, scl_fall, bus_start, bus_stop, in_frame;
  logic acc, wr_ctrl, wr_addr, wr_data, clr, set, unmapped;
  logic fifo_in_ready, fifo_valid, pop;
  logic [7:0] fifo_data, load_byte, status_rd;

  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("Transmit buffer needs at least two entries.");
  end

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    return addr == off;
  endfunction

  function automatic logic addr_match(input logic [7:0] b, input tst_state_type st);
    return st.ack_en & ((b[7:1] == st.own_addr) | ((b[7:1] == 7'h00) & st.gce));
  endfunction

  // Edges are taken from the second synchroniser stage and its delayed copy.
  assign scl_rise = s.scl_s2 & ~s.scl_p;
  assign scl_fall = ~s.scl_s2 & s.scl_p;
  assign bus_start = s.scl_s2 & s.scl_p & s.sda_p & ~s.sda_s2;
  assign bus_stop = s.scl_s2 & s.scl_p & ~s.sda_p & s.sda_s2;
  assign in_frame = ((s.fsm == TST_ADDR) & (s.bitcnt != 4'h0)) | (s.fsm == TST_ADDR_ACK) |
                    (s.fsm == TST_TX) | (s.fsm == TST_TX_ACK);

  assign acc = psel_in & penable_in;
  assign wr_ctrl = acc & pwrite_in & hit(paddr_in, `TST_OFF_CTRL);
  assign wr_addr = acc & pwrite_in & hit(paddr_in, `TST_OFF_ADDR);
  assign wr_data = acc & pwrite_in & hit(paddr_in, `TST_OFF_DATA);
  assign unmapped = ~(hit(paddr_in, `TST_OFF_CTRL) | hit(paddr_in, `TST_OFF_STATUS) |
                      hit(paddr_in, `TST_OFF_DATA) | hit(paddr_in, `TST_OFF_ADDR));
  // A data write waits while the buffer is full, so software is stalled, not dropped.
  assign pready_out = ~(wr_data & ~fifo_in_ready);
  assign pslverr_out = acc & unmapped;
  assign clr = wr_ctrl & pwdata_in[`TST_CTRL_FLAG];
  assign status_rd = (s.flag ? s.code : `TST_CODE_F8) & `TST_PRESC_MASK;
  // An empty buffer sends all ones rather than stale data.
  assign load_byte = fifo_valid ? fifo_data : `TST_IDLE_BYTE;

  tst_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .in_valid_in(wr_data),
    .in_ready_out(fifo_in_ready),
    .in_data_in(pwdata_in[7:0]),
    .out_valid_out(fifo_valid),
    .out_ready_in(pop),
    .out_data_out(fifo_data)
  );

  always_comb begin
    n = s;
    set = 1'b0;
    pop = 1'b0;
    n.scl_s1 = scl_in;
    n.scl_s2 = s.scl_s1;
    n.scl_p = s.scl_s2;
    n.sda_s1 = sda_in;
    n.sda_s2 = s.sda_s1;
    n.sda_p = s.sda_s2;
    n.start_pulse = 1'b0;
    if (psel_in & ~penable_in) begin
      case (1'b1)
        hit(paddr_in, `TST_OFF_CTRL): n.rdata = {24'h00_0000, s.flag, s.ack_en, s.start_req,
                                                 s.stop_req, 1'b0, s.enable, 2'b00};
        hit(paddr_in, `TST_OFF_STATUS): n.rdata = {24'h00_0000, status_rd};
        hit(paddr_in, `TST_OFF_DATA): n.rdata = {24'h00_0000, s.data_last};
        hit(paddr_in, `TST_OFF_ADDR): n.rdata = {24'h00_0000, s.own_addr, s.gce};
        default: n.rdata = 32'h0000_0000;
      endcase
    end
    if (wr_ctrl) begin
      n.ack_en = pwdata_in[`TST_CTRL_ACK];
      n.start_req = pwdata_in[`TST_CTRL_START];
      n.stop_req = pwdata_in[`TST_CTRL_STOP];
      n.enable = pwdata_in[`TST_CTRL_EN];
    end
    if (wr_addr) begin
      n.own_addr = pwdata_in[7:1];
      n.gce = pwdata_in[0];
    end
    if (bus_start) begin
      n.busy = 1'b1;
    end
    if (bus_stop) begin
      n.busy = 1'b0;
    end
    if (arb_lost_in) begin
      n.arb_pend = 1'b1;
    end
    if (s.start_pend & ~s.busy & ~bus_start) begin
      n.start_pulse = 1'b1;
      n.start_pend = 1'b0;
    end
    if ((bus_start | bus_stop) & in_frame) begin
      n.fsm = TST_BERR;
      n.code = `TST_CODE_00;
      set = 1'b1;
      n.sda_oe = 1'b0;
      n.scl_oe = 1'b0;
    end else begin
      case (s.fsm)
        TST_IDLE, TST_IGNORE: begin
          if (bus_start & s.enable) begin
            n.fsm = TST_ADDR;
            n.bitcnt = 4'h0;
          end else if (bus_stop) begin
            n.fsm = TST_IDLE;
          end
        end
        TST_ADDR: begin
          if (bus_stop) begin
            n.fsm = TST_IDLE;
          end else if (scl_rise) begin
            n.shift = {s.shift[6:0], s.sda_s2};
            n.bitcnt = s.bitcnt + 4'h1;
          end else if (scl_fall && s.bitcnt == 4'h8) begin
            // Only reads are served here; writes and general calls belong to the receiver.
            if (addr_match(s.shift, s) && s.shift[7:1] != 7'h00 && s.shift[0]) begin
              n.fsm = TST_ADDR_ACK;
              n.sda_oe = 1'b1;
            end else begin
              n.fsm = TST_IGNORE;
              n.arb_pend = 1'b0;
            end
          end
        end
        TST_ADDR_ACK: begin
          if (scl_fall) begin
            n.sda_oe = 1'b0;
            n.scl_oe = 1'b1;
            n.code = s.arb_pend ? `TST_CODE_B0 : `TST_CODE_A8;
            n.arb_pend = 1'b0;
            set = 1'b1;
            n.fsm = TST_WAIT;
          end
        end
        TST_WAIT: begin
          if (clr) begin
            if (s.code == `TST_CODE_C0 || s.code == `TST_CODE_C8) begin
              n.fsm = TST_IDLE;
              n.start_pend = pwdata_in[`TST_CTRL_START];
            end else begin
              pop = fifo_valid;
              n.data_last = load_byte;
              n.last = ~pwdata_in[`TST_CTRL_ACK];
              n.shift = {load_byte[6:0], 1'b0};
              n.sda_oe = ~load_byte[7];
              n.bitcnt = 4'h1;
              n.scl_oe = 1'b0;
              n.fsm = TST_TX;
            end
          end
        end
        TST_TX: begin
          if (scl_fall) begin
            if (s.bitcnt == 4'h8) begin
              n.sda_oe = 1'b0;
              n.fsm = TST_TX_ACK;
            end else begin
              n.sda_oe = ~s.shift[7];
              n.shift = {s.shift[6:0], 1'b0};
              n.bitcnt = s.bitcnt + 4'h1;
            end
          end
        end
        TST_TX_ACK: begin
          if (scl_rise) begin
            n.ackbit = ~s.sda_s2;
          end else if (scl_fall) begin
            set = 1'b1;
            n.fsm = TST_WAIT;
            if (!s.ackbit) begin
              n.code = `TST_CODE_C0;
            end else if (s.last) begin
              n.code = `TST_CODE_C8;
            end else begin
              n.code = `TST_CODE_B8;
              n.scl_oe = 1'b1;
            end
          end
        end
        TST_BERR: begin
          if (clr & pwdata_in[`TST_CTRL_STOP]) begin
            n.fsm = TST_IDLE;
            n.stop_req = 1'b0;
          end
        end
        default: n.fsm = TST_IDLE;
      endcase
    end
    // A hardware set in the same cycle as a software clear keeps the flag high.
    n.flag = (s.flag & ~clr) | set;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s <= '0;
      s.fsm <= TST_IDLE;
      s.ack_en <= `TST_RST_ACK;
      s.enable <= `TST_RST_EN;
      s.own_addr <= `TST_RST_OWN;
      s.gce <= `TST_RST_GCE;
      s.scl_s1 <= 1'b1;
      s.scl_s2 <= 1'b1;
      s.scl_p <= 1'b1;
      s.sda_s1 <= 1'b1;
      s.sda_s2 <= 1'b1;
      s.sda_p <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign prdata_out = s.rdata;
  assign lines_out = '{scl_o: 1'b0, scl_oe: s.scl_oe, sda_o: 1'b0, sda_oe: s.sda_oe};
  assign master_start_out = s.start_pulse;
  assign event_flag_out = s.flag;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_clear_in_wait;
    (s.fsm == TST_WAIT) && clr;
  endsequence
  sequence s_tx_ack_fall;
    (s.fsm == TST_TX_ACK) && scl_fall && !((bus_start || bus_stop));
  endsequence

  property p_addr_read;
    (s.fsm == TST_ADDR_ACK) && scl_fall && !s.arb_pend && !bus_start && !bus_stop
      |=> s.flag && s.code == 8'hA8 && s.scl_oe;
  endproperty
  a_addr_read: assert property (p_addr_read) else $error("No A8 after address.");
  property p_arb_read;
    (s.fsm == TST_ADDR_ACK) && scl_fall && s.arb_pend && !bus_start && !bus_stop
      |=> s.flag && s.code == 8'hB0;
  endproperty
  a_arb_read: assert property (p_arb_read) else $error("No B0 after lost arbitration.");
  property p_data_ack;
    s_tx_ack_fall ##0 (s.ackbit && !s.last) |=> s.flag && s.code == 8'hB8;
  endproperty
  a_data_ack: assert property (p_data_ack) else $error("No B8 after acked byte.");
  property p_data_nack;
    s_tx_ack_fall ##0 !s.ackbit |=> s.flag && s.code == 8'hC0 && !s.scl_oe;
  endproperty
  a_data_nack: assert property (p_data_nack) else $error("No C0 after nack.");
  property p_last_ack;
    s_tx_ack_fall ##0 (s.ackbit && s.last) |=> s.flag && s.code == 8'hC8;
  endproperty
  a_last_ack: assert property (p_last_ack) else $error("No C8 after acked last byte.");
  property p_load_next;
    s_clear_in_wait ##0 (s.code != 8'hC0 && s.code != 8'hC8)
      |=> s.fsm == TST_TX && s.last == !$past(pwdata_in[6]) && !s.scl_oe ##1 !s.flag;
  endproperty
  a_load_next: assert property (p_load_next) else $error("Byte not loaded on clear.");
  property p_drop_out;
    s_clear_in_wait ##0 (s.code == 8'hC0 || s.code == 8'hC8)
      |=> s.fsm == TST_IDLE && s.start_pend == $past(pwdata_in[5]);
  endproperty
  a_drop_out: assert property (p_drop_out) else $error("No drop out after last byte.");
  property p_no_flag_status;
    !s.flag |-> status_rd == 8'hF8;
  endproperty
  a_no_flag_status: assert property (p_no_flag_status) else $error("Idle status wrong.");
  property p_presc_zero;
    status_rd[2:0] == 3'b000;
  endproperty
  a_presc_zero: assert property (p_presc_zero) else $error("Prescaler bits not zero.");
  property p_bus_error;
    (bus_start || bus_stop) && in_frame |=> s.fsm == TST_BERR && s.flag && s.code == 8'h00;
  endproperty
  a_bus_error: assert property (p_bus_error) else $error("Bus error missed.");
  property p_recover;
    (s.fsm == TST_BERR) && clr && pwdata_in[4]
      |=> s.fsm == TST_IDLE && !s.stop_req && s.ack_en == $past(pwdata_in[6]);
  endproperty
  a_recover: assert property (p_recover) else $error("Recovery failed.");
  property p_release;
    (s.fsm == TST_BERR) || (s.fsm == TST_IDLE) || (s.fsm == TST_IGNORE)
      |-> !lines_out.sda_oe && !lines_out.scl_oe;
  endproperty
  a_release: assert property (p_release) else $error("Line driven while out.");
endmodule

`default_nettype wire

// File: tst_slave_tx_tb_top.sv
// Self-checking bench for the two-wire slave transmitter, its registers and its buffer.
`timescale 1ns/1ps
`include "tst_defs.svh"
`default_nettype none
module tst_slave_tx_tb_top;
  import tst_pkg::*;
  localparam logic [31:0] c_flag = 32'h0000_0080;
  localparam logic [31:0] c_ack = 32'h0000_0040;
  localparam logic [31:0] c_start = 32'h0000_0020;
  localparam logic [31:0] c_stop = 32'h0000_0010;
  localparam logic [31:0] c_en = 32'h0000_0004;
  localparam logic [7:0] ctl = `TST_OFF_CTRL;
  localparam logic [6:0] own = 7'h2A;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, arb_lost = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, q, n;
  logic [31:0] starts = 32'h0000_0000;
  logic pready, pslverr, slverr, mstart, flag, m_scl_oe, m_sda_oe, scl, sda;
  tst_line_type lines;
  int errors = 0, n_checks = 0, cycles = 0;
  always #25 clk_in = ~clk_in;
  // Both lines have pull-ups: released means high.
  assign scl = ~(m_scl_oe | lines.scl_oe);
  assign sda = ~(m_sda_oe | lines.sda_oe);
  tst_slave_tx #(.FIFO_DEPTH(8)) dut_u (
    .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .scl_in(scl), .sda_in(sda),
    .lines_out(lines), .arb_lost_in(arb_lost), .master_start_out(mstart),
    .event_flag_out(flag)
  );
  tst_master_model mdl_u (
    .clk_in(clk_in), .scl_in(scl), .sda_in(sda), .scl_oe_out(m_scl_oe),
    .sda_oe_out(m_sda_oe)
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_in);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    tick(1);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    tick(1);
    penable <= 1'b1;
    tick(1);
    while (pready !== 1'b1) tick(1);
    q = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wc(input logic [31:0] d);
    apb(1'b1, ctl, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask
  task automatic status(input logic [7:0] c);
    rd(`TST_OFF_STATUS, {24'h0, c});
  endtask
  task automatic wait_flag();
    int k = 0;
    while (flag !== 1'b1 && k < 400) begin
      tick(1);
      k++;
    end
    chkb(flag, 1'b1);
  endtask
  task automatic addr(input logic exp_ack);
    logic a;
    mdl_u.start_cond();
    mdl_u.send_byte({own, 1'b1}, a);
    chkb(a, exp_ack);
  endtask
  task automatic recv(input logic ack, input logic [7:0] e);
    logic [7:0] b;
    mdl_u.recv_byte(ack, b);
    chk({24'h0, b}, {24'h0, e});
  endtask
  task automatic t_regs();
    rd(ctl, 32'h0000_0000);
    rd(`TST_OFF_ADDR, 32'h0000_0000);
    status(`TST_CODE_F8);
    rd(8'h10, 32'h0000_0000);
    chkb(slverr, 1'b1);
    apb(1'b1, `TST_OFF_ADDR, {24'h0, own, 1'b1});
    wc(c_ack | c_en);
    rd(ctl, c_ack | c_en);
    $display("test regs done");
  endtask
  task automatic t_stream();
    apb(1'b1, `TST_OFF_DATA, 32'h0000_005A);
    apb(1'b1, `TST_OFF_DATA, 32'h0000_00C3);
    addr(1'b0);
    wait_flag();
    status(`TST_CODE_A8);
    chkb(lines.scl_oe, 1'b1);
    wc(c_flag | c_ack | c_en);
    rd(`TST_OFF_DATA, 32'h0000_005A);
    recv(1'b0, 8'h5A);
    wait_flag();
    status(`TST_CODE_B8);
    wc(c_flag | c_en);
    recv(1'b0, 8'hC3);
    wait_flag();
    status(`TST_CODE_C8);
    wc(c_flag | c_ack | c_en);
    status(`TST_CODE_F8);
    recv(1'b1, `TST_IDLE_BYTE);
    chkb(flag, 1'b0);
    mdl_u.stop_cond();
    $display("test stream done");
  endtask
  task automatic t_nack();
    apb(1'b1, `TST_OFF_DATA, 32'h0000_0081);
    addr(1'b0);
    wait_flag();
    wc(c_flag | c_en);
    recv(1'b1, 8'h81);
    wait_flag();
    status(`TST_CODE_C0);
    wc(c_flag | c_en);
    mdl_u.stop_cond();
    addr(1'b1);
    chkb(flag, 1'b0);
    mdl_u.stop_cond();
    wc(c_ack | c_en);
    addr(1'b0);
    wait_flag();
    wc(c_flag | c_en);
    recv(1'b1, `TST_IDLE_BYTE);
    wait_flag();
    status(`TST_CODE_C0);
    n = starts;
    wc(c_flag | c_start | c_ack | c_en);
    tick(20);
    chk(starts, n);
    mdl_u.stop_cond();
    tick(20);
    chk(starts, n + 1);
    $display("test nack done");
  endtask
  task automatic t_arb();
    fork
      addr(1'b0);
      begin
        tick(30);
        arb_lost <= 1'b1;
        tick(1);
        arb_lost <= 1'b0;
      end
    join
    wait_flag();
    status(`TST_CODE_B0);
    wc(c_flag | c_en);
    recv(1'b1, `TST_IDLE_BYTE);
    wait_flag();
    wc(c_flag | c_ack | c_en);
    mdl_u.stop_cond();
    $display("test arb done");
  endtask
  task automatic t_berr();
    logic g;
    mdl_u.start_cond();
    for (int i = 0; i < 3; i++) begin
      mdl_u.clk_bit(1'b1, 1'b0, g);
    end
    mdl_u.fall();
    mdl_u.stop_cond();
    wait_flag();
    status(`TST_CODE_00);
    chk({28'h0, lines}, 32'h0000_0000);
    wc(c_flag | c_stop | c_ack | c_en);
    rd(ctl, c_ack | c_en);
    status(`TST_CODE_F8);
    chk({28'h0, lines}, 32'h0000_0000);
    addr(1'b0);
    wait_flag();
    status(`TST_CODE_A8);
    $display("test berr done");
  endtask
  // The buffer is only drained by clearing the flag, so a stalled write is ended by reset.
  task automatic t_full();
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, `TST_OFF_DATA, 32'(i));
    end
    fork
      apb(1'b1, `TST_OFF_DATA, 32'h0000_0099);
    join_none
    tick(6);
    chkb(pready, 1'b0);
    rst_in <= 1'b1;
    tick(3);
    rst_in <= 1'b0;
    tick(3);
    rd(ctl, 32'h0000_0000);
    status(`TST_CODE_F8);
    $display("test full done");
  endtask
  always @(posedge clk_in) begin
    if (mstart === 1'b1) begin
      starts <= starts + 1;
    end
  end
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      finish_test();
    end
  end
  initial begin
    tick(16);
    rst_in <= 1'b0;
    tick(3);
    t_regs();
    t_stream();
    t_nack();
    t_arb();
    t_berr();
    t_full();
    finish_test();
  end
endmodule
`default_nettype wire
